// File: shared/tpg_pkg.sv
// shared constants and types of the test packet generator block
package tpg_pkg;
  localparam int ADDR_W = 10;
  localparam int DEF_PKT_LEN = 64;
  localparam logic [9:0] OFS_CFG = 10'h123;
  localparam logic [9:0] OFS_PAT_LO = 10'h124;
  localparam logic [9:0] OFS_PAT_MID = 10'h125;
  localparam logic [9:0] OFS_PAT_HI = 10'h126;
  localparam logic [9:0] OFS_DA_LO = 10'h127;
  localparam logic [9:0] OFS_DA_MID = 10'h128;
  localparam logic [9:0] OFS_DA_HI = 10'h129;
  localparam logic [9:0] OFS_CRC = 10'h12a;
  localparam logic [9:0] OFS_TX_LO = 10'h12b;
  localparam logic [9:0] OFS_TX_HI = 10'h12c;
  localparam logic [9:0] OFS_TX_ERR = 10'h12d;
  localparam logic [9:0] OFS_RX_LO = 10'h12e;
  localparam logic [9:0] OFS_RX_HI = 10'h12f;
  localparam logic [9:0] OFS_RX_ERR = 10'h130;
  localparam logic [9:0] OFS_IRQ_ST = 10'h131;
  localparam logic [9:0] OFS_IRQ_CLR = 10'h132;
  localparam logic [9:0] OFS_IRQ_EN = 10'h133;
  localparam logic [9:0] OFS_GEN_CTL = 10'h134;
  localparam logic [15:0] RST_VAL = 16'h0000;
  localparam logic [1:0] MODE_INC = 2'h0;
  localparam logic [1:0] MODE_FIX = 2'h1;
  localparam logic [2:0] MAX_VLD = 3'h6;
  localparam logic [2:0] CNT_CONT = 3'h7;
  localparam int CRC_TX_BIT = 0;
  localparam int CRC_RX_BIT = 1;
  localparam int IRQ_TX_CRC = 0;
  localparam int IRQ_RX_CRC = 1;
  localparam int IRQ_DONE = 2;
  localparam int CTL_START = 0;
  localparam int CTL_STOP = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam logic [2:0] DA_BYTES = 3'h6;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  typedef struct packed {
    logic [7:0] fix_byte;
    logic [1:0] mode;
    logic [2:0] vld_bytes;
    logic [2:0] pkt_code;
  } tpg_cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tpg_req_t;

  typedef struct packed {
    logic eop;
    logic crc_err;
  } tpg_rep_t;

  typedef struct packed {
    logic valid;
    logic sof;
    logic [7:0] data;
  } tpg_rxb_t;

  typedef enum {G_IDLE, G_SEND, G_WAIT} tpg_gen_st_t;
  typedef enum {RS_NONE, RS_LOW, RS_HIGH} tpg_rd_seq_t;

  // packets requested by a count code; the top code never ends
  function automatic logic [19:0] pkt_target(input logic [2:0] code);
    case (code)
      3'h0: return 20'h00001;
      3'h1: return 20'h0000a;
      3'h2: return 20'h00064;
      3'h3: return 20'h003e8;
      3'h4: return 20'h02710;
      3'h5: return 20'h186a0;
      default: return 20'hf4240;
    endcase
  endfunction
endpackage

// File: logic/tpg_stat_grp.sv
// packet and error counter pair cleared by an ordered read
module tpg_stat_grp
  import tpg_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // events
  input wire logic pkt_evt,
  input wire logic err_evt,
  // read strobes
  input wire logic rd_low,
  input wire logic rd_high,
  input wire logic rd_err,
  // counts
  output logic [31:0] pkt_cnt,
  output logic [15:0] err_cnt
);
  tpg_rd_seq_t seq;
  logic clr;

  // clear only after low, high, then error word
  assign clr = rd_err && seq == RS_HIGH;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      seq <= RS_NONE;
    end else begin
      case (seq)
        RS_NONE: if (rd_low) seq <= RS_LOW;
        RS_LOW: begin
          if (rd_high) seq <= RS_HIGH;
          else if (rd_err) seq <= RS_NONE;
        end
        RS_HIGH: begin
          if (rd_low) seq <= RS_LOW;
          else if (rd_high || rd_err) seq <= RS_NONE;
        end
        default: seq <= RS_NONE;
      endcase
    end
  end

  // an event in the clearing cycle is kept
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pkt_cnt <= 32'h0;
    end else if (clr) begin
      pkt_cnt <= {31'h0, pkt_evt};
    end else if (pkt_evt) begin
      pkt_cnt <= pkt_cnt + 32'h1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      err_cnt <= 16'h0;
    end else if (clr) begin
      err_cnt <= {15'h0, err_evt};
    end else if (err_evt) begin
      err_cnt <= err_cnt + 16'h1;
    end
  end

  sequence s_full_read;
    rd_low ##1 rd_high ##1 rd_err;
  endsequence

  a_seq_clear: assert property (
    @(posedge core_clk) disable iff (!resetn)
    s_full_read ##0 (!pkt_evt && !err_evt)
    |=> pkt_cnt == 32'h0 && err_cnt == 16'h0)
    else $error("ordered read did not clear counters");

  a_count_step: assert property (
    @(posedge core_clk) disable iff (!resetn)
    pkt_evt && !clr |=> pkt_cnt == $past(pkt_cnt) + 32'h1)
    else $error("packet counter did not step");

  a_no_early_clr: assert property (
    @(posedge core_clk) disable iff (!resetn)
    rd_err && seq != RS_HIGH && !err_evt
    |=> err_cnt == $past(err_cnt))
    else $error("error counter cleared out of order");
endmodule // tpg_stat_grp

// File: logic/tpg_top.sv
// test packet generator, address match, crc flags and statistics
module tpg_top
  import tpg_pkg::*;
#(
  parameter int PKT_LEN = DEF_PKT_LEN
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // register port
  input wire tpg_req_t reg_req,
  output logic [15:0] reg_rdata,
  // generated byte stream
  output logic [7:0] gen_data,
  output logic gen_valid,
  output logic gen_last,
  input wire logic gen_ready,
  // transmit and receive packet reports
  input wire tpg_rep_t tx_rep,
  input wire tpg_rep_t rx_rep,
  // received bytes
  input wire tpg_rxb_t rx_in,
  // results
  output logic da_match,
  output logic irq
);
  localparam int IDXW = $clog2(PKT_LEN);
  localparam logic [IDXW-1:0] LAST_IDX = IDXW'(PKT_LEN - 1);

  tpg_cfg_t cfg;
  logic [47:0] pat;
  logic [47:0] da_ref;
  logic [47:0] da_sh;
  logic [47:0] next_da;
  logic [47:0] pat_sh;
  logic [2:0] da_idx;
  logic [1:0] crc_flags;
  logic [2:0] irq_st;
  logic [2:0] irq_en;
  logic [2:0] irq_clr;
  logic [2:0] irq_ev;
  tpg_gen_st_t state;
  logic [IDXW-1:0] byte_idx;
  logic [19:0] sent;
  logic [19:0] next_sent;
  logic [15:0] lfsr;
  logic [7:0] next_byte;
  logic [2:0] vld_eff;
  logic done;
  logic stop_req;
  logic take;
  logic emit;
  logic in_pat;
  logic fin;
  logic start_wr;
  logic stop_wr;
  logic [31:0] tx_cnt;
  logic [15:0] tx_err;
  logic [31:0] rx_cnt;
  logic [15:0] rx_err;

  function automatic logic wr_at(input tpg_req_t q, input logic [9:0] a);
    return q.wr && q.addr == a;
  endfunction

  function automatic logic rd_at(input tpg_req_t q, input logic [9:0] a);
    return q.rd && q.addr == a;
  endfunction

  // software writable configuration
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cfg <= tpg_cfg_t'(RST_VAL);
      pat <= {3{RST_VAL}};
      da_ref <= {3{RST_VAL}};
      irq_en <= 3'h0;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        OFS_CFG: cfg <= tpg_cfg_t'(reg_req.wdata);
        OFS_PAT_LO: pat[15:0] <= reg_req.wdata;
        OFS_PAT_MID: pat[31:16] <= reg_req.wdata;
        OFS_PAT_HI: pat[47:32] <= reg_req.wdata;
        OFS_DA_LO: da_ref[15:0] <= reg_req.wdata;
        OFS_DA_MID: da_ref[31:16] <= reg_req.wdata;
        OFS_DA_HI: da_ref[47:32] <= reg_req.wdata;
        OFS_IRQ_EN: irq_en <= reg_req.wdata[2:0];
        default: ;
      endcase
    end
  end

  assign start_wr = wr_at(reg_req, OFS_GEN_CTL) && reg_req.wdata[CTL_START];
  assign stop_wr = wr_at(reg_req, OFS_GEN_CTL) && reg_req.wdata[CTL_STOP];
  assign irq_clr = wr_at(reg_req, OFS_IRQ_CLR) ? reg_req.wdata[2:0] : 3'h0;

  // payload byte selection
  assign vld_eff = (cfg.vld_bytes > MAX_VLD) ? MAX_VLD : cfg.vld_bytes;
  assign in_pat = byte_idx < IDXW'(vld_eff);
  assign pat_sh = pat << {byte_idx[2:0], 3'h0};
  assign take = !gen_valid || gen_ready;
  assign emit = state == G_SEND && take;

  always_comb begin
    next_byte = cfg.fix_byte;
    if (in_pat) begin
      next_byte = pat_sh[47:40];
    end else if (cfg.mode[1]) begin
      next_byte = lfsr[7:0];
    end else if (cfg.mode == MODE_INC) begin
      next_byte = 8'(byte_idx);
    end
  end

  // packet count bookkeeping
  assign next_sent = sent + 20'h1;
  assign fin = state == G_WAIT && tx_rep.eop && cfg.pkt_code != CNT_CONT
    && next_sent == pkt_target(cfg.pkt_code);

  // generator sequencing
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= G_IDLE;
      byte_idx <= '0;
      sent <= 20'h0;
    end else begin
      case (state)
        G_IDLE: begin
          if (start_wr) begin
            state <= G_SEND;
            byte_idx <= '0;
            sent <= 20'h0;
          end
        end
        G_SEND: begin
          if (take) begin
            byte_idx <= byte_idx + IDXW'(1);
            if (byte_idx == LAST_IDX) state <= G_WAIT;
          end
        end
        G_WAIT: begin
          if (tx_rep.eop) begin
            byte_idx <= '0;
            sent <= next_sent;
            if (fin || stop_req) state <= G_IDLE;
            else state <= G_SEND;
          end
        end
        default: state <= G_IDLE;
      endcase
    end
  end

  // completion flag holds until the next start
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      done <= 1'b0;
    end else if (fin) begin
      done <= 1'b1;
    end else if (start_wr && state == G_IDLE) begin
      done <= 1'b0;
    end
  end

  // stop takes effect at the next packet boundary
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stop_req <= 1'b0;
    end else if (state == G_IDLE) begin
      stop_req <= 1'b0;
    end else if (stop_wr) begin
      stop_req <= 1'b1;
    end
  end

  // pseudo-random source, one step per random byte
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lfsr <= LFSR_SEED;
    end else if (emit && !in_pat && cfg.mode[1]) begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  // registered byte stream output
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gen_valid <= 1'b0;
      gen_data <= 8'h0;
      gen_last <= 1'b0;
    end else if (emit) begin
      gen_valid <= 1'b1;
      gen_data <= next_byte;
      gen_last <= byte_idx == LAST_IDX;
    end else if (gen_ready) begin
      gen_valid <= 1'b0;
      gen_last <= 1'b0;
    end
  end

  // destination address capture and compare, first byte highest
  assign next_da = {da_sh[39:0], rx_in.data};

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      da_sh <= 48'h0;
      da_idx <= 3'h0;
      da_match <= 1'b0;
    end else if (rx_in.valid) begin
      if (rx_in.sof) begin
        da_sh <= {40'h0, rx_in.data};
        da_idx <= 3'h1;
        da_match <= 1'b0;
      end else if (da_idx < DA_BYTES) begin
        da_sh <= next_da;
        da_idx <= da_idx + 3'h1;
        if (da_idx == DA_BYTES - 3'h1) begin
          da_match <= next_da == da_ref;
        end
      end
    end
  end

  // crc flags follow the last packet of each path
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      crc_flags <= 2'h0;
    end else begin
      if (tx_rep.eop) crc_flags[CRC_TX_BIT] <= tx_rep.crc_err;
      if (rx_rep.eop) crc_flags[CRC_RX_BIT] <= rx_rep.crc_err;
    end
  end

  // sticky interrupt status, set wins over clear
  assign irq_ev[IRQ_TX_CRC] = tx_rep.eop && tx_rep.crc_err;
  assign irq_ev[IRQ_RX_CRC] = rx_rep.eop && rx_rep.crc_err;
  assign irq_ev[IRQ_DONE] = fin;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_st <= 3'h0;
    end else begin
      irq_st <= (irq_st & ~irq_clr) | irq_ev;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_st & irq_en);
    end
  end

  // statistic counter groups
  tpg_stat_grp u_tx_stat (
    .core_clk(core_clk),
    .resetn(resetn),
    .pkt_evt(tx_rep.eop),
    .err_evt(irq_ev[IRQ_TX_CRC]),
    .rd_low(rd_at(reg_req, OFS_TX_LO)),
    .rd_high(rd_at(reg_req, OFS_TX_HI)),
    .rd_err(rd_at(reg_req, OFS_TX_ERR)),
    .pkt_cnt(tx_cnt),
    .err_cnt(tx_err)
  );

  tpg_stat_grp u_rx_stat (
    .core_clk(core_clk),
    .resetn(resetn),
    .pkt_evt(rx_rep.eop),
    .err_evt(irq_ev[IRQ_RX_CRC]),
    .rd_low(rd_at(reg_req, OFS_RX_LO)),
    .rd_high(rd_at(reg_req, OFS_RX_HI)),
    .rd_err(rd_at(reg_req, OFS_RX_ERR)),
    .pkt_cnt(rx_cnt),
    .err_cnt(rx_err)
  );

  // read data stand one cycle after the strobe
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= RST_VAL;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        OFS_CFG: reg_rdata <= cfg;
        OFS_PAT_LO: reg_rdata <= pat[15:0];
        OFS_PAT_MID: reg_rdata <= pat[31:16];
        OFS_PAT_HI: reg_rdata <= pat[47:32];
        OFS_DA_LO: reg_rdata <= da_ref[15:0];
        OFS_DA_MID: reg_rdata <= da_ref[31:16];
        OFS_DA_HI: reg_rdata <= da_ref[47:32];
        OFS_CRC: reg_rdata <= {14'h0, crc_flags};
        OFS_TX_LO: reg_rdata <= tx_cnt[15:0];
        OFS_TX_HI: reg_rdata <= tx_cnt[31:16];
        OFS_TX_ERR: reg_rdata <= tx_err;
        OFS_RX_LO: reg_rdata <= rx_cnt[15:0];
        OFS_RX_HI: reg_rdata <= rx_cnt[31:16];
        OFS_RX_ERR: reg_rdata <= rx_err;
        OFS_IRQ_ST: reg_rdata <= {13'h0, irq_st};
        OFS_IRQ_EN: reg_rdata <= {13'h0, irq_en};
        OFS_GEN_CTL: reg_rdata <= {14'h0, done, state != G_IDLE};
        default: reg_rdata <= RST_VAL;
      endcase
    end else begin
      reg_rdata <= RST_VAL;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_fixed_payload: assert property (
    emit && !in_pat && cfg.mode == MODE_FIX
    |=> gen_valid && gen_data == $past(cfg.fix_byte))
    else $error("fixed payload byte wrong");

  a_random_mode: assert property (
    emit && !in_pat && cfg.mode[1] |=> gen_data == $past(lfsr[7:0]))
    else $error("random payload byte wrong");

  a_pattern_first: assert property (
    emit && byte_idx == '0 && vld_eff != 3'h0
    |=> gen_data == $past(pat[47:40]))
    else $error("first pattern byte wrong");

  a_pkt_count: assert property (
    state == G_WAIT && tx_rep.eop && cfg.pkt_code == CNT_CONT && !stop_req
    |=> state == G_SEND)
    else $error("continuous generator stopped by itself");

  sequence s_finish;
    fin ##1 (done && state == G_IDLE);
  endsequence

  a_done_flag: assert property (
    fin |-> s_finish)
    else $error("done flag not raised at end");

  a_inc_payload: assert property (
    emit && !in_pat && cfg.mode == MODE_INC && byte_idx != '0
    ##1 emit && !in_pat && cfg.mode == MODE_INC && byte_idx != '0
    |=> gen_data == $past(gen_data) + 8'h1)
    else $error("incrementing payload did not step");

  a_tx_crc_flag: assert property (
    tx_rep.eop |=> crc_flags[CRC_TX_BIT] == $past(tx_rep.crc_err))
    else $error("transmit crc flag wrong");

  a_rx_crc_flag: assert property (
    rx_rep.eop |=> crc_flags[CRC_RX_BIT] == $past(rx_rep.crc_err))
    else $error("receive crc flag wrong");

  a_da_compare: assert property (
    rx_in.valid && !rx_in.sof && da_idx == 3'h5
    |=> da_match == ({$past(da_sh[39:0]), $past(rx_in.data)} == da_ref))
    else $error("destination match wrong");
endmodule // tpg_top

// File: bench/test_tpg_top.sv
// self-checking testbench of the test packet generator block
module test_tpg_top
  import tpg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PLEN = 8;
  logic core_clk;
  logic resetn;
  tpg_req_t reg_req;
  logic [15:0] reg_rdata;
  logic [7:0] gen_data;
  logic gen_valid;
  logic gen_last;
  logic gen_ready;
  logic stall;
  tpg_rep_t tx_rep;
  tpg_rep_t rx_rep;
  tpg_rxb_t rx_in;
  logic da_match;
  logic irq;
  int fail_count;
  int checked;

  tpg_top #(.PKT_LEN(PLEN)) i_tpg_top (
    .core_clk(core_clk), .resetn(resetn), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .gen_data(gen_data), .gen_valid(gen_valid),
    .gen_last(gen_last), .gen_ready(gen_ready), .tx_rep(tx_rep),
    .rx_rep(rx_rep), .rx_in(rx_in), .da_match(da_match), .irq(irq)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // sink accepts every cycle, or every other cycle while stalling
  always @(posedge core_clk) gen_ready <= stall ? ~gen_ready : 1'b1;

  task automatic final_report;
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_req <= '{addr:a, wdata:d, wr:1'b1, rd:1'b0};
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [15:0] e,
                    input logic [15:0] m = 16'hffff);
    @(posedge core_clk);
    reg_req <= '{addr:a, wdata:16'h0, wr:1'b0, rd:1'b1};
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask

  task automatic rep(input logic rx, input logic err);
    @(posedge core_clk);
    if (rx) rx_rep <= '{eop:1'b1, crc_err:err};
    else tx_rep <= '{eop:1'b1, crc_err:err};
    @(posedge core_clk);
    rx_rep <= '0;
    tx_rep <= '0;
  endtask

  // three reads with no gap; each answer is taken at the following edge
  task automatic rd_burst(input logic [9:0] a, input logic [15:0] e0,
                          input logic [15:0] e1, input logic [15:0] e2);
    @(posedge core_clk);
    reg_req <= '{addr:a, wdata:16'h0, wr:1'b0, rd:1'b1};
    @(posedge core_clk);
    reg_req.addr <= a + 10'h1;
    @(posedge core_clk);
    chk(reg_rdata, e0);
    reg_req.addr <= a + 10'h2;
    @(posedge core_clk);
    chk(reg_rdata, e1);
    reg_req.rd <= 1'b0;
    @(posedge core_clk);
    chk(reg_rdata, e2);
  endtask

  // runs the generator and checks every byte handed to the sink; random payload bytes are checked for gen_last only
  task automatic gen_run(input tpg_cfg_t c, input logic [47:0] p,
                         input int npkt, input bit stop);
    int n, g, vc;
    logic [7:0] e;
    vc = (c.vld_bytes > MAX_VLD) ? int'(MAX_VLD) : int'(c.vld_bytes);
    wr(OFS_CFG, c);
    wr(OFS_PAT_LO, p[15:0]);
    wr(OFS_PAT_MID, p[31:16]);
    wr(OFS_PAT_HI, p[47:32]);
    wr(OFS_IRQ_CLR, 16'h0007);
    rd(OFS_CFG, c);
    rd(OFS_PAT_HI, p[47:32]);
    wr(OFS_GEN_CTL, 16'h0001);
    for (int k = 0; k < npkt; k++) begin
      n = 0;
      g = 0;
      while (n < PLEN && g < 2000) begin
        @(negedge core_clk);
        g++;
        if (gen_valid && gen_ready) begin
          if (n < vc) e = p[47-8*n -: 8];
          else if (c.mode == MODE_FIX) e = c.fix_byte;
          else e = n[7:0];
          if (n < vc) chk(gen_data, e);
          else if (!c.mode[1]) chk(gen_data, e);
          chk(gen_last, n == PLEN-1);
          n++;
        end
      end
      if (g >= 2000) begin
        fail_count++;
        final_report();
      end
      if (stop && k == npkt-1) wr(OFS_GEN_CTL, 16'h0002);
      rep(1'b0, 1'b0);
    end
    if (stop) rd(OFS_GEN_CTL, 16'h0000);
    else begin
      rd(OFS_GEN_CTL, 16'h0002);
      rd(OFS_IRQ_ST, 16'h0004);
    end
    @(negedge core_clk);
    chk(gen_valid, 1'b0);
  endtask

  task automatic reset_values;
    for (int a = 'h123; a <= 'h134; a++) rd(a[9:0], RST_VAL);
    wr(10'h3ff, 16'hffff);
    rd(10'h3ff, 16'h0000);
  endtask

  task automatic gen_modes;
    logic [47:0] p;
    p = 48'h1122_3344_5566;
    gen_run('{8'ha5, MODE_FIX, 3'h2, 3'h0}, p, 1, 0);
    gen_run('{8'h00, MODE_INC, 3'h7, 3'h1}, p, 10, 0);
    stall = 1'b1;
    gen_run('{8'h00, 2'h2, 3'h3, 3'h0}, p, 1, 0);
    stall = 1'b0;
    gen_run('{8'h00, 2'h3, 3'h6, 3'h0}, p, 1, 0);
    gen_run('{8'h3c, MODE_FIX, 3'h0, CNT_CONT}, p, 2, 1);
  endtask

  task automatic stats;
    rd(OFS_TX_ERR, 16'h0000);
    rd(OFS_TX_LO, 16'd15);
    rd(OFS_TX_ERR, 16'h0000);
    rd(OFS_TX_LO, 16'd15);
    rd(OFS_TX_HI, 16'h0000);
    rd(OFS_TX_ERR, 16'h0000);
    rd(OFS_TX_LO, 16'h0000);
    rep(1'b0, 1'b1);
    rep(1'b0, 1'b0);
    rep(1'b0, 1'b1);
    rep(1'b1, 1'b1);
    rep(1'b1, 1'b0);
    rd(OFS_CRC, 16'h0001);
    rep(1'b1, 1'b1);
    rd(OFS_CRC, 16'h0003);
    rd(OFS_TX_LO, 16'd3);
    rd(OFS_TX_HI, 16'd0);
    rd(OFS_TX_ERR, 16'd2);
    rd(OFS_RX_LO, 16'd3);
    rd(OFS_RX_HI, 16'd0);
    rd(OFS_RX_ERR, 16'd2);
    rd(OFS_TX_LO, 16'd0);
    rd(OFS_TX_ERR, 16'd0);
    rd(OFS_RX_LO, 16'd0);
    rd(OFS_RX_ERR, 16'd0);
    rep(1'b0, 1'b1);
    rep(1'b0, 1'b1);
    rd_burst(OFS_TX_LO, 16'd2, 16'd0, 16'd2);
    rd(OFS_TX_LO, 16'd0);
    rd(OFS_TX_ERR, 16'd0);
  endtask

  task automatic irq_path;
    wr(OFS_IRQ_CLR, 16'h0007);
    rd(OFS_IRQ_ST, 16'h0000);
    wr(OFS_IRQ_EN, 16'h0002);
    rep(1'b0, 1'b1);
    repeat (2) @(negedge core_clk);
    chk(irq, 1'b0);
    rd(OFS_IRQ_ST, 16'h0001);
    rep(1'b1, 1'b1);
    repeat (2) @(negedge core_clk);
    chk(irq, 1'b1);
    wr(OFS_IRQ_CLR, 16'h0002);
    repeat (2) @(negedge core_clk);
    chk(irq, 1'b0);
    rd(OFS_IRQ_EN, 16'h0002);
    rd(OFS_IRQ_CLR, 16'h0000);
    wr(OFS_IRQ_EN, 16'h0001);
    repeat (2) @(negedge core_clk);
    chk(irq, 1'b1);
  endtask

  task automatic da_frame(input logic [47:0] d, input logic exp);
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      rx_in <= '{valid:1'b1, sof:(i == 0), data:d[47-8*i -: 8]};
    end
    @(posedge core_clk);
    rx_in <= '0;
    repeat (2) @(posedge core_clk);
    #1 chk(da_match, exp);
  endtask

  task automatic da_check;
    wr(OFS_DA_LO, 16'he5f6);
    wr(OFS_DA_MID, 16'hc3d4);
    wr(OFS_DA_HI, 16'ha1b2);
    rd(OFS_DA_LO, 16'he5f6);
    rd(OFS_DA_MID, 16'hc3d4);
    rd(OFS_DA_HI, 16'ha1b2);
    da_frame(48'ha1b2_c3d4_e5f6, 1'b1);
    da_frame(48'ha1b2_c3d4_e5f7, 1'b0);
    da_frame(48'ha1b2_c3d4_e5f6, 1'b1);
    da_frame(48'h21b2_c3d4_e5f6, 1'b0);
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    fail_count++;
    final_report();
  end

  initial begin
    resetn = 1'b0;
    reg_req = '0;
    gen_ready = 1'b0;
    stall = 1'b0;
    tx_rep = '0;
    rx_rep = '0;
    rx_in = '0;
    fail_count = 0;
    checked = 0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    reset_values();
    gen_modes();
    stats();
    irq_path();
    da_check();
    final_report();
  end
endmodule // test_tpg_top
